// file: design/pattern_test_pkg.sv
// holds offsets, field positions, reset values and modes of the
// test pattern control block
// assumes a 16-bit register port already decoded from management frames
package pattern_test_pkg;

    // ------------------------------------------------------------
    // register access
    // ------------------------------------------------------------
    localparam logic [4:0]  DEVICE_ADDR        = 5'h03;
    localparam logic [15:0] SEED_A_WORD0_ADDR  = 16'h0022;
    localparam logic [15:0] SEED_A_WORD1_ADDR  = 16'h0023;
    localparam logic [15:0] SEED_A_WORD2_ADDR  = 16'h0024;
    localparam logic [15:0] SEED_A_TOP_ADDR    = 16'h0025;
    localparam logic [15:0] SEED_B_WORD0_ADDR  = 16'h0026;
    localparam logic [15:0] SEED_B_WORD1_ADDR  = 16'h0027;
    localparam logic [15:0] SEED_B_WORD2_ADDR  = 16'h0028;
    localparam logic [15:0] SEED_B_TOP_ADDR    = 16'h0029;
    localparam logic [15:0] CONTROL_ADDR       = 16'h002A;
    localparam logic [15:0] ERROR_COUNT_ADDR   = 16'h002B;
    localparam logic [15:0] VENDOR_CONTROL_ADDR = 16'h8000;
    localparam logic [15:0] VENDOR_STATUS_ADDR = 16'h8010;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int SEED_WIDTH        = 58;
    localparam int SEED_TOP_WIDTH    = 10;
    localparam int CONTROL_WIDTH     = 6;
    localparam int RX_PRBS_BIT       = 5;
    localparam int TX_PRBS_BIT       = 4;
    localparam int TX_PATTERN_BIT    = 3;
    localparam int RX_PATTERN_BIT    = 2;
    localparam int TYPE_SELECT_BIT   = 1;
    localparam int DATA_SELECT_BIT   = 0;
    localparam int RUN_LENGTH_LSB    = 4;
    localparam int RUN_LENGTH_WIDTH  = 4;
    localparam int ERROR_FLAG_BIT    = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [57:0] SEED_RESET       = 58'h0;
    localparam logic [5:0]  CONTROL_RESET    = 6'h00;
    localparam logic [3:0]  RUN_LENGTH_RESET = 4'hB;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;

    // ------------------------------------------------------------
    // pattern constants
    // ------------------------------------------------------------
    // start state of the prbs31 generator, any value nonzero in bits 30:0 works
    localparam logic [57:0] PRBS_START       = 58'h3FF_FFFF_FFFF_FFFF;
    // local fault ordered set, byte 0 sent first
    localparam logic [63:0] LF_PATTERN       = 64'h0100_0000_0100_009C;
    // count of the last byte before seed A and seed B swap
    localparam logic [6:0]  RESEED_LAST      = 7'h7F;
    // bytes of history needed before the checker is primed
    localparam logic [3:0]  PRIME_LAST       = 4'h8;

    // ------------------------------------------------------------
    // transmit modes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TX_NORMAL    = 4'h1,
        TX_PRBS      = 4'h2,
        TX_SCRAMBLED = 4'h4,
        TX_SQUARE    = 4'h8
    } tx_mode_type;

endpackage : pattern_test_pkg

// file: design/pattern_step_if.sv
// holds the bundle between the control block and its lfsr step
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
`default_nettype none

interface pattern_step_if;
    logic [57:0] history;      // newest bit at bit 0
    logic [7:0]  dataIn;       // byte to scramble or to check
    logic        longPoly;     // 1: 58-bit scrambler, 0: prbs31
    logic        shiftInput;   // 1: history takes input bits
    logic [7:0]  dataOut;      // stepped byte
    logic [57:0] historyNext;  // history after eight bits

    // the step logic
    modport engine (
        input  history, dataIn, longPoly, shiftInput,
        output dataOut, historyNext
    );
    // the block that owns the history
    modport owner (
        output history, dataIn, longPoly, shiftInput,
        input  dataOut, historyNext
    );
endinterface : pattern_step_if

`default_nettype wire

// file: design/pattern_step.sv
// holds eight bit-steps of a shared lfsr scrambler and checker
// assumes the owner keeps the history in its own flip-flops
`timescale 1ns/1ps
`default_nettype none

module pattern_step (
    // link to the owner
    pattern_step_if.engine stepIf
);

    // ------------------------------------------------------------
    // bit-serial unroll, bit 0 of the byte first
    // ------------------------------------------------------------
    logic [57:0] hist [0:8];  // history before each bit
    logic [7:0]  outBits;     // stepped bits

    assign hist[0] = stepIf.history;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            logic fb;   // feedback of the chosen polynomial
            assign fb = stepIf.longPoly ?
                        (hist[i][57] ^ hist[i][38]) :
                        (hist[i][30] ^ hist[i][27]);
            // scramble, or compare against prediction
            assign outBits[i] = stepIf.dataIn[i] ^ fb;
            // self-synchronous checkers shift the input bit in
            assign hist[i+1] = {hist[i][56:0],
                                stepIf.shiftInput ? stepIf.dataIn[i]
                                                  : outBits[i]};
        end
    endgenerate

    assign stepIf.dataOut     = outBits;
    assign stepIf.historyNext = hist[8];

endmodule : pattern_step

`default_nettype wire

// file: design/pcs_test_pattern_control.sv
// holds the test pattern registers, generator and checker of the pcs
// assumes register strobes are decoded from management frames upstream
// and that transmit and receive bytes are synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - seed A bits 57:48 at 0x25 9:0
// - seed B in 0x26..0x29, low first
// - reserved upper bits read zero
// - bit 5 enables receive prbs31 check
// - bit 4 sends prbs31 instead of traffic
// - bit 3 sends selected test pattern
// - bit 2 checks received pseudo-random pattern, square wave not checked
// - bit 1: square wave or pseudo-random
// - control fields at 0x2A zero after reset
// - read-only error counter at 0x2B, resets zero
// - counter counts error bytes, clears on read
// - square run length 7:4, reset 1011
// - seed A low 48 bits at 0x22..0x24
// - sticky error flag, cleared by reading
module pcs_test_pattern_control (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // register port
    input  wire logic [4:0]  devAddr,
    input  wire logic [15:0] regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [15:0] regWriteData,
    output logic      [15:0] regReadData,
    output logic             regReadValid,
    // transmit path
    input  wire logic [7:0]  txData,
    output logic      [7:0]  txOut,
    // receive path
    input  wire logic [7:0]  rxData,
    input  wire logic        rxValid,
    output logic      [7:0]  rxOut,
    output logic             rxOutValid
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [57:0] seedA;        // first pattern seed
        logic [57:0] seedB;        // second pattern seed
        logic [5:0]  control;      // pattern test control
        logic [3:0]  runLength;    // square run length
        logic [15:0] errorTally;   // pattern error tally
        logic        errorFlag;    // pattern error flag
        pattern_test_pkg::tx_mode_type txMode;  // active tx mode
        logic [57:0] txHist;       // generator history
        logic [57:0] rxHist;       // checker history
        logic [7:0]  txOut;        // transmit byte
        logic [7:0]  rxOut;        // receive byte
        logic        rxOutValid;   // receive byte valid
        logic [15:0] readData;     // read answer
        logic        readValid;    // read answer strobe
        logic [2:0]  txPos;        // data pattern byte index
        logic [2:0]  rxPos;        // expected pattern byte index
        logic [6:0]  reseedCount;  // bytes since last seed load
        logic        useSeedB;     // seed loaded last was B
        logic [3:0]  squareCount;  // bytes in current run
        logic        squareLevel;  // current run is ones
        logic [3:0]  primeCount;   // checker fill level
        logic        checkPrev;    // checker enabled last cycle
    } state_type;

    state_type stateReg;   // registered state
    state_type stateNext;  // next state

    // ------------------------------------------------------------
    // lfsr steps for transmit and receive
    // ------------------------------------------------------------
    pattern_step_if txStepIf ();
    pattern_step_if rxStepIf ();

    pattern_step u_txStep (
        .stepIf (txStepIf.engine)
    );

    pattern_step u_rxStep (
        .stepIf (rxStepIf.engine)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // byte of the selected data pattern
    function automatic logic [7:0] dataByte(input logic zeros,
                                            input logic [2:0] pos);
        logic [63:0] shifted;
        shifted = pattern_test_pkg::LF_PATTERN >> {pos, 3'h0};
        dataByte = zeros ? 8'h00 : shifted[7:0];
    endfunction : dataByte

    // register read decode, upper reserved bits zero
    function automatic logic [15:0] readMux(input state_type s,
                                            input logic [15:0] addr);
        readMux = 16'h0000;
        case (addr)
            pattern_test_pkg::SEED_A_WORD0_ADDR: readMux = s.seedA[15:0];
            pattern_test_pkg::SEED_A_WORD1_ADDR: readMux = s.seedA[31:16];
            pattern_test_pkg::SEED_A_WORD2_ADDR: readMux = s.seedA[47:32];
            pattern_test_pkg::SEED_A_TOP_ADDR:
                readMux = {6'h00, s.seedA[57:48]};
            pattern_test_pkg::SEED_B_WORD0_ADDR: readMux = s.seedB[15:0];
            pattern_test_pkg::SEED_B_WORD1_ADDR: readMux = s.seedB[31:16];
            pattern_test_pkg::SEED_B_WORD2_ADDR: readMux = s.seedB[47:32];
            pattern_test_pkg::SEED_B_TOP_ADDR:
                readMux = {6'h00, s.seedB[57:48]};
            pattern_test_pkg::CONTROL_ADDR:
                readMux = {10'h000, s.control};
            pattern_test_pkg::ERROR_COUNT_ADDR:
                readMux = s.errorTally;
            pattern_test_pkg::VENDOR_CONTROL_ADDR:
                readMux = {8'h00, s.runLength, 4'h0};
            pattern_test_pkg::VENDOR_STATUS_ADDR:
                readMux = {7'h00, s.errorFlag, 8'h00};
            default: readMux = 16'h0000;
        endcase
    endfunction : readMux

    // ------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------
    logic                          hit;         // access to this device
    logic                          rxPrbsCheck; // prbs31 check active
    logic                          rxSeedCheck; // seeded check active
    logic                          checking;    // any check active
    pattern_test_pkg::tx_mode_type modeSel;     // requested tx mode
    logic [7:0]                    expected;    // expected check byte
    logic                          byteError;   // checked byte is bad
    logic [15:0]                   tallyBase;   // tally after read clear

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        stateNext = stateReg;
        hit = (devAddr == pattern_test_pkg::DEVICE_ADDR);

        // register reads answer one cycle later
        stateNext.readValid = regRead && hit;
        stateNext.readData  = (regRead && hit) ?
                              readMux(stateReg, regAddr) : 16'h0000;

        // register writes, reserved bits dropped
        if (regWrite && hit) begin
            case (regAddr)
                pattern_test_pkg::SEED_A_WORD0_ADDR:
                    stateNext.seedA[15:0] = regWriteData;
                pattern_test_pkg::SEED_A_WORD1_ADDR:
                    stateNext.seedA[31:16] = regWriteData;
                pattern_test_pkg::SEED_A_WORD2_ADDR:
                    stateNext.seedA[47:32] = regWriteData;
                pattern_test_pkg::SEED_A_TOP_ADDR:
                    stateNext.seedA[57:48] = regWriteData[9:0];
                pattern_test_pkg::SEED_B_WORD0_ADDR:
                    stateNext.seedB[15:0] = regWriteData;
                pattern_test_pkg::SEED_B_WORD1_ADDR:
                    stateNext.seedB[31:16] = regWriteData;
                pattern_test_pkg::SEED_B_WORD2_ADDR:
                    stateNext.seedB[47:32] = regWriteData;
                pattern_test_pkg::SEED_B_TOP_ADDR:
                    stateNext.seedB[57:48] = regWriteData[9:0];
                pattern_test_pkg::CONTROL_ADDR:
                    stateNext.control = regWriteData[5:0];
                pattern_test_pkg::VENDOR_CONTROL_ADDR:
                    stateNext.runLength = regWriteData[7:4];
                // counter and status are read only
                default: stateNext.control = stateReg.control;
            endcase
        end

        // transmit mode, prbs31 takes priority over the other test
        if (stateReg.control[pattern_test_pkg::TX_PRBS_BIT])
            modeSel = pattern_test_pkg::TX_PRBS;
        else if (stateReg.control[pattern_test_pkg::TX_PATTERN_BIT])
            modeSel = stateReg.control[pattern_test_pkg::TYPE_SELECT_BIT]
                      ? pattern_test_pkg::TX_SQUARE
                      : pattern_test_pkg::TX_SCRAMBLED;
        else
            modeSel = pattern_test_pkg::TX_NORMAL;
        stateNext.txMode = modeSel;

        // transmit step: scrambler for seeded, free lfsr for prbs31
        txStepIf.history    = stateReg.txHist;
        txStepIf.longPoly   = (stateReg.txMode ==
                               pattern_test_pkg::TX_SCRAMBLED);
        txStepIf.shiftInput = 1'b0;
        txStepIf.dataIn     = txStepIf.longPoly ?
            dataByte(stateReg.control[pattern_test_pkg::DATA_SELECT_BIT],
                     stateReg.txPos) : 8'h00;

        // transmit byte per mode
        case (stateReg.txMode)
            pattern_test_pkg::TX_PRBS: begin
                stateNext.txOut  = txStepIf.dataOut;
                stateNext.txHist = txStepIf.historyNext;
            end
            pattern_test_pkg::TX_SCRAMBLED: begin
                stateNext.txOut       = txStepIf.dataOut;
                stateNext.txHist      = txStepIf.historyNext;
                stateNext.txPos       = stateReg.txPos + 3'h1;
                stateNext.reseedCount = stateReg.reseedCount + 7'h01;
                // swap seeds every block of bytes
                if (stateReg.reseedCount == pattern_test_pkg::RESEED_LAST)
                begin
                    stateNext.txHist   = stateReg.useSeedB ?
                                         stateReg.seedA :
                                         stateReg.seedB;
                    stateNext.useSeedB = ~stateReg.useSeedB;
                end
            end
            pattern_test_pkg::TX_SQUARE: begin
                stateNext.txOut = stateReg.squareLevel ? 8'hFF : 8'h00;
                // run length of zero behaves as one
                if ({1'b0, stateReg.squareCount} + 5'h01 >=
                    {1'b0, stateReg.runLength}) begin
                    stateNext.squareCount = 4'h0;
                    stateNext.squareLevel = ~stateReg.squareLevel;
                end else begin
                    stateNext.squareCount = stateReg.squareCount + 4'h1;
                end
            end
            pattern_test_pkg::TX_NORMAL: stateNext.txOut = txData;
            default: stateNext.txOut = txData;
        endcase

        // restart the generator on any mode change
        if (modeSel != stateReg.txMode) begin
            stateNext.txHist      = (modeSel == pattern_test_pkg::TX_PRBS)
                                    ? pattern_test_pkg::PRBS_START
                                    : stateReg.seedA;
            stateNext.useSeedB    = 1'b0;
            stateNext.reseedCount = 7'h00;
            stateNext.txPos       = 3'h0;
            stateNext.squareCount = 4'h0;
            stateNext.squareLevel = 1'b0;
        end

        // receive checks: prbs31 first, square wave is not checked
        rxPrbsCheck = stateReg.control[pattern_test_pkg::RX_PRBS_BIT];
        rxSeedCheck = ~rxPrbsCheck &&
                      stateReg.control[pattern_test_pkg::RX_PATTERN_BIT] &&
                      ~stateReg.control[pattern_test_pkg::TYPE_SELECT_BIT];
        checking    = rxPrbsCheck || rxSeedCheck;
        stateNext.checkPrev = checking;

        // self-synchronous check: history takes the received bits
        rxStepIf.history    = stateReg.rxHist;
        rxStepIf.dataIn     = rxData;
        rxStepIf.longPoly   = ~rxPrbsCheck;
        rxStepIf.shiftInput = 1'b1;
        expected = rxPrbsCheck ? 8'h00 :
            dataByte(stateReg.control[pattern_test_pkg::DATA_SELECT_BIT],
                     stateReg.rxPos);
        byteError = 1'b0;

        // receive path passes data through unchanged
        stateNext.rxOut      = rxData;
        stateNext.rxOutValid = rxValid;

        if (!checking || !stateReg.checkPrev) begin
            // new check: refill history first
            stateNext.primeCount = 4'h0;
            stateNext.rxPos      = 3'h0;
        end else if (rxValid) begin
            stateNext.rxHist = rxStepIf.historyNext;
            stateNext.rxPos  = stateReg.rxPos + 3'h1;
            if (stateReg.primeCount == pattern_test_pkg::PRIME_LAST) begin
                byteError = |(rxStepIf.dataOut ^ expected);
            end else begin
                stateNext.primeCount = stateReg.primeCount + 4'h1;
            end
        end

        // tally: read clears it, an error in the same cycle still counts
        tallyBase = (regRead && hit &&
                     regAddr == pattern_test_pkg::ERROR_COUNT_ADDR)
                    ? pattern_test_pkg::COUNT_RESET
                    : stateReg.errorTally;
        if (byteError && tallyBase != 16'hFFFF)
            stateNext.errorTally = tallyBase + 16'h0001;
        else
            stateNext.errorTally = tallyBase;

        // flag: set wins over read clear
        if (byteError && rxSeedCheck)
            stateNext.errorFlag = 1'b1;
        else if (regRead && hit &&
                 regAddr == pattern_test_pkg::VENDOR_STATUS_ADDR)
            stateNext.errorFlag = 1'b0;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stateReg             <= '0;
            stateReg.seedA       <= pattern_test_pkg::SEED_RESET;
            stateReg.seedB       <= pattern_test_pkg::SEED_RESET;
            stateReg.control     <= pattern_test_pkg::CONTROL_RESET;
            stateReg.runLength   <= pattern_test_pkg::RUN_LENGTH_RESET;
            stateReg.errorTally  <= pattern_test_pkg::COUNT_RESET;
            stateReg.txMode      <= pattern_test_pkg::TX_NORMAL;
        end else begin
            stateReg <= stateNext;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign regReadData  = stateReg.readData;
    assign regReadValid = stateReg.readValid;
    assign txOut        = stateReg.txOut;
    assign rxOut        = stateReg.rxOut;
    assign rxOutValid   = stateReg.rxOutValid;

endmodule : pcs_test_pattern_control

`default_nettype wire

// file: tb/pcs_test_pattern_checker.sv
// assertions on the register port and receive pass-through
// assumes it is bound into pcs_test_pattern_control
`timescale 1ns/1ps
`default_nettype none

module pcs_test_pattern_checker (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // register port
    input wire logic [4:0]  devAddr,
    input wire logic [15:0] regAddr,
    input wire logic        regRead,
    input wire logic [15:0] regReadData,
    input wire logic        regReadValid,
    // receive path
    input wire logic [7:0]  rxData,
    input wire logic        rxValid,
    input wire logic [7:0]  rxOut,
    input wire logic        rxOutValid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // -----------------------------------------------
    // read answers come one cycle after the strobe
    // -----------------------------------------------
    AST_READ_ANSWER: assert property (regRead && devAddr == 5'h03
        |=> regReadValid) else $error("read not answered");
    AST_ANSWER_CAUSE: assert property (regReadValid
        |-> $past(regRead) && $past(devAddr) == 5'h03)
        else $error("answer without read");
    AST_OTHER_DEVICE: assert property (regRead && devAddr != 5'h03
        |=> !regReadValid) else $error("foreign device answered");
    AST_IDLE_ZERO: assert property (!regReadValid
        |-> regReadData == 16'h0000) else $error("data while idle");
    // reserved upper bits of seed tops and control
    AST_SEED_TOP: assert property (regRead && (regAddr == 16'h0025
        || regAddr == 16'h0029) |=> regReadData[15:10] == 6'h00)
        else $error("seed top reserved bits set");
    AST_CTRL_TOP: assert property (regRead && regAddr == 16'h002A
        |=> regReadData[15:6] == 10'h000) else $error("control high bits");
    // receive bytes pass through one cycle later
    AST_RX_PASS: assert property (rxValid |=> rxOutValid
        && rxOut == $past(rxData)) else $error("receive byte lost");
    AST_RESET_QUIET: assert property (disable iff (1'b0) rst
        |=> !regReadValid && !rxOutValid) else $error("busy in reset");
endmodule : pcs_test_pattern_checker

bind pcs_test_pattern_control pcs_test_pattern_checker
    pcs_test_pattern_checker_i (.clk_sys(clk_sys), .rst(rst),
    .devAddr(devAddr), .regAddr(regAddr), .regRead(regRead),
    .regReadData(regReadData), .regReadValid(regReadValid),
    .rxData(rxData), .rxValid(rxValid), .rxOut(rxOut),
    .rxOutValid(rxOutValid));

`default_nettype wire

// file: tb/link_partner_model.sv
// link partner that echoes transmit bytes back, with bit-0 fault
// assumes the same clock as the block
`timescale 1ns/1ps
`default_nettype none

module link_partner_model (
    // clock
    input wire logic       clk_sys,
    // control from the bench
    input wire logic       echoOn,
    input wire logic       flipBit,
    // serial side
    input wire logic [7:0] txOut,
    output var logic [7:0] rxData,
    output var logic       rxValid
);
    initial rxData = 8'h00;
    initial rxValid = 1'b0;
    // echo while on, otherwise a line toggling every cycle
    always @(posedge clk_sys) begin
        rxValid <= echoOn;
        rxData  <= echoOn ? (txOut ^ {7'h00, flipBit}) : ~rxData;
    end
endmodule : link_partner_model

`default_nettype wire

// file: tb/pcs_test_pattern_control_test.sv
// self-checking bench for the test pattern block
// assumes the partner model loops transmit bytes to receive
`timescale 1ns/1ps
`default_nettype none

module pcs_test_pattern_control_test;
    logic clk_sys = 0, rst = 1, regWrite = 0, regRead = 0, rxValid;
    logic echoOn = 0, flipBit = 0, regReadValid, rxOutValid;
    logic [4:0]  devAddr = 5'h03;
    logic [15:0] regAddr = 0, regWriteData = 0, regReadData;
    logic [7:0]  txData = 0, txOut, rxData, rxOut;
    int error_cnt = 0, n_compared = 0;
    always #5 clk_sys = ~clk_sys;
    pcs_test_pattern_control pcs_test_pattern_control_i (.*);
    link_partner_model link_partner_model_i (.*);
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [15:0] a, logic [15:0] d);
        @(posedge clk_sys) {regAddr, regWriteData, regWrite} <= {a, d, 1'b1};
        @(posedge clk_sys) regWrite <= 0;
    endtask : wr
    task automatic rd(logic [4:0] dv, logic [15:0] a, logic [15:0] exp);
        @(posedge clk_sys) {devAddr, regAddr, regRead} <= {dv, a, 1'b1};
        @(posedge clk_sys) {devAddr, regRead} <= {5'h03, 1'b0};
        #1 chk("valid", regReadValid, dv == 5'h03);
        chk("read", regReadData, exp);
    endtask : rd
    task automatic t_reset;
        for (int a = 'h22; a <= 'h2B; a++) rd(5'h03, a[15:0], 0);
        rd(5'h03, 16'h8000, 16'h00B0);
        rd(5'h04, 16'h002A, 0);
    endtask : t_reset
    task automatic t_regs;
        wr(16'h0022, 16'hA5C3); wr(16'h0026, 16'h5A3C);
        wr(16'h0025, 16'hFFFF); wr(16'h0029, 16'hFFFF);
        wr(16'h002A, 16'hFFFF); wr(16'h002B, 16'h1234);
        wr(16'h0030, 16'hFFFF);
        rd(5'h03, 16'h0022, 16'hA5C3);
        rd(5'h03, 16'h0026, 16'h5A3C);
        rd(5'h03, 16'h0025, 16'h03FF);
        rd(5'h03, 16'h0029, 16'h03FF);
        rd(5'h03, 16'h002A, 16'h003F);
        rd(5'h03, 16'h002B, 16'h0000);
        rd(5'h03, 16'h0030, 16'h0000);
        wr(16'h002A, 0);
    endtask : t_regs
    task automatic t_prbs;
        wr(16'h002A, 16'h0010); echoOn <= 1;
        wr(16'h002A, 16'h0030); repeat (40) @(posedge clk_sys);
        rd(5'h03, 16'h002B, 0);
        @(posedge clk_sys) flipBit <= 1;
        @(posedge clk_sys) flipBit <= 0;
        repeat (20) @(posedge clk_sys);
        rd(5'h03, 16'h002B, 16'h0002);
        rd(5'h03, 16'h002B, 0);
        rd(5'h03, 16'h8010, 0);
        echoOn <= 0; wr(16'h002A, 0);
    endtask : t_prbs
    // seeded scrambler over local fault data, looped back and checked
    task automatic t_seeded;
        wr(16'h002A, 16'h0008); echoOn <= 1;
        wr(16'h002A, 16'h000C); repeat (20) @(posedge clk_sys);
        rd(5'h03, 16'h002B, 0);
        @(posedge clk_sys) flipBit <= 1;
        @(posedge clk_sys) flipBit <= 0;
        repeat (20) @(posedge clk_sys);
        rd(5'h03, 16'h002B, 16'h0003);
        rd(5'h03, 16'h8010, 16'h0100);
        rd(5'h03, 16'h8010, 0);
        echoOn <= 0; wr(16'h002A, 0);
    endtask : t_seeded
    task automatic t_square;
        int n;
        logic [7:0] exp [4] = '{8'h00, 8'hFF, 8'hFF, 8'h00};
        wr(16'h8000, 16'h0020); wr(16'h002A, 16'h000A); n = 0;
        do @(posedge clk_sys) #1; while (txOut !== 8'hFF && ++n < 50);
        do @(posedge clk_sys) #1; while (txOut !== 8'h00 && ++n < 50);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys) #1 chk("square", txOut, exp[i]);
        end
        wr(16'h002A, 0); txData <= 8'h5A; repeat (3) @(posedge clk_sys);
        #1 chk("normal", txOut, 8'h5A);
    endtask : t_square
    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 0;
        t_reset(); t_regs(); t_prbs(); t_seeded(); t_square();
        end_of_test();
    end
endmodule : pcs_test_pattern_control_test

`default_nettype wire
